// [rtl/ulpi_phy_ctrl.sv]
// Behaviour
// - Host mode with external drive bit set pulls switch enable low.
// - Internal drive bit set turns on internal VBUS supply.
// - Active-low asynchronous reset clears every circuit; pin use optional.
// - DIR low by default; bus is input, device listens.
// - DIR high only for data to link, or blocking during boot/low power.
// - Chip select high floats DATA, DIR, NXT and ignores STP.
// - STP while DIR high aborts; DIR falls next interface cycle.
// - NXT low by default; with DIR low it requests next link byte.
// - With DIR high, NXT marks a valid USB byte on the bus.
// - NXT stays low for register read data and status bytes.
// - Device outputs interface clock that times all bus signalling.
// - Synchronous mode is default, entered after power-up clock settles.
// - Synchronous mode carries chirp, packets, register access, status bytes.
// - Every DIR change gives one turnaround cycle with bus invalid.
// - Low-power and serial modes give data lines fixed roles.
// - DIR high with NXT low means status byte unless register read data.
// - STP held high wakes low-power or serial mode back to synchronous.
// - Clearing suspend bit switches bus to low-power signal map.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module ulpi_phy_ctrl
	import ulpi_phy_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	// Register bus
	input  wire apb_req_t   apb_req,
	output apb_rsp_t        apb_rsp,
	// Link bus
	output logic            ifc_clk,
	input  wire logic       stp,
	input  wire logic       chip_select_n,
	input  wire logic [7:0] data_i,
	output ulpi_pins_t      ulpi,
	// Analog front end levels
	input  wire logic [1:0] linestate,
	input  wire logic       int_req,
	// VBUS control
	output logic            vbus_switch_enable_n_o,
	output logic            vbus_switch_enable_n_oe,
	output logic            internal_vbus_enable
);

	typedef struct packed {
		phy_state_t st;
		logic [1:0] div;
		logic       ifc_clk;
		logic [7:0] boot_cnt;
		ulpi_pins_t pins;
		logic       psw_oe;
		logic       int_vbus;
		logic [2:0] otg;
		logic       suspend_n;
		logic [1:0] intf;
		logic       tx_pend;
		send_kind_t tx_kind;
		logic [7:0] tx_byte;
		logic [7:0] rx_byte;
		logic       rx_valid;
		logic       aborted;
		apb_rsp_t   rsp;
	} core_t;

	localparam logic [2:0] IDX_NONE = 3'h7;

	core_t       core_reg;
	core_t       core_next;
	logic [12:0] pins_s;
	logic        stp_s;
	logic        cs_s;
	logic [1:0]  ls_s;
	logic        int_s;
	logic [7:0]  din_s;
	logic        tick;
	logic        access;
	logic        done;
	logic [2:0]  acc_idx;

	// Link pins arrive from outside this clock's domain
	pin_sync #(.WIDTH(13)) u_pin_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.d       ({stp, chip_select_n, linestate, int_req, data_i}),
		.q       (pins_s)
	);
	assign {stp_s, cs_s, ls_s, int_s, din_s} = pins_s;

	function automatic logic [2:0] reg_index(input logic [7:0] addr);
		unique case (addr)
			OTG_CONTROL_REGISTER_OFS:  reg_index = 3'h0;
			FUNCTION_CONTROL_REGISTER_OFS: reg_index = 3'h1;
			INTF_CTRL_OFS: reg_index = 3'h2;
			TX_REQ_OFS:    reg_index = 3'h3;
			STATUS_OFS:    reg_index = 3'h4;
			RX_DATA_OFS:   reg_index = 3'h5;
			default:       reg_index = IDX_NONE;
		endcase
	endfunction

	assign tick    = (core_reg.div == DIV_LAST);
	assign acc_idx = reg_index(apb_req.paddr);
	assign access  = apb_req.psel & apb_req.penable & ~core_reg.rsp.pready;
	assign done    = apb_req.psel & apb_req.penable & core_reg.rsp.pready;

	always_comb begin
		core_next = core_reg;
		// Bus pins change at the interface clock's falling edge, mid-period for the link
		core_next.div = tick ? 2'h0 : 2'(core_reg.div + 2'h1);
		core_next.ifc_clk = (core_next.div >= DIV_HALF);
		core_next.psw_oe = core_reg.otg[OTG_HOST_BIT] & core_reg.otg[OTG_EXT_VBUS_BIT];
		core_next.int_vbus = core_reg.otg[OTG_INT_VBUS_BIT];

		// Read data is prepared in the first access cycle, taken when pready is seen
		core_next.rsp.pready = access;
		core_next.rsp.pslverr = access & (acc_idx == IDX_NONE);
		core_next.rsp.prdata = 32'h0;
		if (access && !apb_req.pwrite) begin
			unique case (acc_idx)
				3'h0: core_next.rsp.prdata = {29'h0, core_reg.otg};
				3'h1: core_next.rsp.prdata = {31'h0, core_reg.suspend_n};
				3'h2: core_next.rsp.prdata = {30'h0, core_reg.intf};
				3'h3: core_next.rsp.prdata = {22'h0, core_reg.tx_kind, core_reg.tx_byte};
				3'h4: core_next.rsp.prdata = {21'h0, core_reg.pins.dir, core_reg.aborted,
					core_reg.tx_pend, core_reg.st};
				3'h5: core_next.rsp.prdata = {23'h0, core_reg.rx_valid, core_reg.rx_byte};
				default: core_next.rsp.prdata = 32'h0;
			endcase
		end
		if (done && apb_req.pwrite) begin
			unique case (acc_idx)
				3'h0: core_next.otg = apb_req.pwdata[2:0];
				3'h1: core_next.suspend_n = apb_req.pwdata[FUNC_SUSPEND_BIT];
				3'h2: core_next.intf = apb_req.pwdata[1:0];
				3'h3: begin
					// A request is dropped while one is still waiting
					if (!core_reg.tx_pend) begin
						core_next.tx_pend = 1'b1;
						core_next.tx_byte = apb_req.pwdata[7:0];
						core_next.tx_kind = send_kind_t'(apb_req.pwdata[TX_KIND_LSB +: 2]);
					end
				end
				3'h4: core_next.aborted = 1'b0;
				default: ;
			endcase
		end
		if (done && !apb_req.pwrite && acc_idx == 3'h5) begin
			core_next.rx_valid = 1'b0;
		end

		// Hardware updates below override software clears in the same cycle
		if (tick) begin
			if (cs_s) begin
				// Deselected: float everything, freeze state, disregard STP
				core_next.pins.dir_oe = 1'b0;
				core_next.pins.nxt_oe = 1'b0;
				core_next.pins.data_oe = 8'h00;
			end else begin
				core_next.pins.dir_oe = 1'b1;
				core_next.pins.nxt_oe = 1'b1;
				unique case (core_reg.st)
					ST_BOOT: begin
						// Bus blocked until the interface clock has settled
						core_next.pins.dir = 1'b1;
						if (core_reg.boot_cnt == 8'(POWERUP_TICKS - 8'h01)) begin
							core_next.pins.dir = 1'b0;
							core_next.st = ST_TURN_IN;
						end else begin
							core_next.boot_cnt = 8'(core_reg.boot_cnt + 8'h01);
						end
					end
					ST_IDLE: begin
						if (din_s != 8'h00) begin
							core_next.rx_byte = din_s;
							core_next.rx_valid = 1'b1;
							core_next.pins.nxt = 1'b1;
							core_next.st = ST_RECV;
						end else if (!core_reg.suspend_n || core_reg.intf != 2'h0
							|| core_reg.tx_pend) begin
							core_next.pins.dir = 1'b1;
							core_next.st = ST_TURN_OUT;
						end
					end
					ST_RECV: begin
						if (stp_s) begin
							core_next.pins.nxt = 1'b0;
							core_next.st = ST_IDLE;
						end else begin
							core_next.rx_byte = din_s;
							core_next.rx_valid = 1'b1;
						end
					end
					ST_TURN_OUT: begin
						// Turnaround: DIR is high, data still undriven
						if (stp_s) begin
							core_next.pins.dir = 1'b0;
							core_next.tx_pend = 1'b0;
							core_next.aborted = 1'b1;
							core_next.st = ST_TURN_IN;
						end else if (!core_reg.suspend_n) begin
							// Low power outranks serial if software set both
							core_next.pins.data_oe = LP_OE_MASK;
							core_next.pins.data_o = {4'h0, int_s, 1'b0, ls_s};
							core_next.st = ST_LOWPWR;
						end else if (core_reg.intf != 2'h0) begin
							core_next.pins.data_oe = SER_OE_MASK;
							core_next.pins.data_o = {2'h0, ls_s, int_s, 3'h0};
							core_next.st = ST_SERIAL;
						end else if (core_reg.tx_pend) begin
							core_next.pins.data_oe = 8'hff;
							core_next.pins.data_o = core_reg.tx_byte;
							core_next.pins.nxt = (core_reg.tx_kind == KIND_USB);
							core_next.tx_pend = 1'b0;
							core_next.st = ST_SEND;
						end else begin
							core_next.pins.dir = 1'b0;
							core_next.st = ST_TURN_IN;
						end
					end
					ST_SEND: begin
						if (stp_s) begin
							core_next.aborted = 1'b1;
						end
						core_next.pins.dir = 1'b0;
						core_next.pins.data_oe = 8'h00;
						core_next.pins.nxt = 1'b0;
						core_next.st = ST_TURN_IN;
					end
					ST_LOWPWR: begin
						if (stp_s) begin
							core_next.pins.dir = 1'b0;
							core_next.pins.data_oe = 8'h00;
							core_next.suspend_n = 1'b1;
							core_next.st = ST_TURN_IN;
						end else begin
							// Restores the map after a deselect floated the bus
							core_next.pins.data_oe = LP_OE_MASK;
							core_next.pins.data_o = {4'h0, int_s, 1'b0, ls_s};
						end
					end
					ST_SERIAL: begin
						if (stp_s) begin
							core_next.pins.dir = 1'b0;
							core_next.pins.data_oe = 8'h00;
							core_next.intf = 2'h0;
							core_next.st = ST_TURN_IN;
						end else begin
							core_next.pins.data_oe = SER_OE_MASK;
							core_next.pins.data_o = {2'h0, ls_s, int_s, 3'h0};
						end
					end
					ST_TURN_IN: begin
						// Link's first byte after DIR fell is ignored
						core_next.st = ST_IDLE;
					end
					default: begin
						core_next.pins.dir = 1'b1;
						core_next.pins.data_oe = 8'h00;
						core_next.pins.nxt = 1'b0;
						core_next.st = ST_BOOT;
					end
				endcase
			end
		end
	end

	// DIR comes up high so the link is blocked during reset and boot
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			core_reg <= '{st: ST_BOOT, pins: '{dir: 1'b1, dir_oe: 1'b1, nxt_oe: 1'b1,
				default: '0}, otg: OTG_CONTROL_REGISTER_RST, suspend_n: FUNCTION_CONTROL_REGISTER_RST,
				intf: INTF_CTRL_RST, tx_kind: KIND_RXCMD, default: '0};
		end else begin
			core_reg <= core_next;
		end
	end

	assign apb_rsp                 = core_reg.rsp;
	assign ifc_clk                 = core_reg.ifc_clk;
	assign ulpi                    = core_reg.pins;
	assign vbus_switch_enable_n_o  = 1'b0;
	assign vbus_switch_enable_n_oe = core_reg.psw_oe;
	assign internal_vbus_enable    = core_reg.int_vbus;

	localparam int TICK_WAIT = 8;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	AST_PSW_DRIVE: assert property (
		(core_reg.otg[OTG_HOST_BIT] && core_reg.otg[OTG_EXT_VBUS_BIT]) |=> vbus_switch_enable_n_oe)
		else $error("switch enable not pulled low in host mode");
	AST_INT_VBUS: assert property (
		$rose(core_reg.otg[OTG_INT_VBUS_BIT]) |=> internal_vbus_enable)
		else $error("internal supply not enabled");
	AST_CS_FLOAT: assert property (
		(tick && cs_s) |=> (!ulpi.dir_oe && !ulpi.nxt_oe && ulpi.data_oe == 8'h00))
		else $error("bus driven while deselected");
	AST_ABORT: assert property (
		(tick && !cs_s && stp_s && core_reg.st inside {ST_TURN_OUT, ST_SEND}) |=> !ulpi.dir)
		else $error("DIR not dropped after abort");
	AST_NO_DRIVE_LOW: assert property (
		!ulpi.dir |-> ulpi.data_oe == 8'h00)
		else $error("data driven with DIR low");
	AST_TURNAROUND: assert property (
		$rose(ulpi.dir) |-> (ulpi.data_oe == 8'h00) [*4])
		else $error("no turnaround after DIR rose");
	AST_NXT_STATUS: assert property (
		(core_reg.st == ST_SEND && ulpi.dir && !ulpi.nxt) |-> core_reg.tx_kind != KIND_USB)
		else $error("USB byte sent without NXT");
	AST_NXT_DEFAULT: assert property (
		ulpi.nxt |-> core_reg.st inside {ST_RECV, ST_SEND})
		else $error("NXT high outside a transfer");
	AST_BOOT_DIR: assert property (
		core_reg.st == ST_BOOT |-> ulpi.dir)
		else $error("DIR low during boot");
	AST_WAKE: assert property (
		(tick && !cs_s && stp_s && core_reg.st == ST_LOWPWR)
		|=> (core_reg.suspend_n && !ulpi.dir) ##[1:TICK_WAIT] core_reg.st == ST_IDLE)
		else $error("low power not left on STP");
	AST_APB_ANSWER: assert property (
		(apb_req.psel && apb_req.penable && !apb_rsp.pready) |=> apb_rsp.pready)
		else $error("APB access not answered");

	COV_ABORT: cover property (tick && stp_s && core_reg.st == ST_TURN_OUT);
	COV_RECV: cover property (core_reg.st == ST_RECV ##1 core_reg.st == ST_IDLE);
	COV_SEND_USB: cover property (core_reg.st == ST_SEND && ulpi.nxt);
	COV_LOWPWR: cover property (core_reg.st == ST_LOWPWR);

endmodule

// [pkg/ulpi_phy_pkg.sv]
package ulpi_phy_pkg;

	// Interface clock is an integer division of the reference clock
	localparam int         REF_CLK_MHZ   = 250;
	localparam int         IFC_CLK_MHZ   = 60;
	localparam int         CLK_DIV       = REF_CLK_MHZ / IFC_CLK_MHZ;
	localparam logic [1:0] DIV_LAST      = 2'(CLK_DIV - 1);
	localparam logic [1:0] DIV_HALF      = 2'(CLK_DIV / 2);
	localparam logic [7:0] POWERUP_TICKS = 8'h10;

	// Register byte offsets
	localparam logic [7:0] OTG_CONTROL_REGISTER_OFS  = 8'h00;
	localparam logic [7:0] FUNCTION_CONTROL_REGISTER_OFS = 8'h04;
	localparam logic [7:0] INTF_CTRL_OFS = 8'h08;
	localparam logic [7:0] TX_REQ_OFS    = 8'h0c;
	localparam logic [7:0] STATUS_OFS    = 8'h10;
	localparam logic [7:0] RX_DATA_OFS   = 8'h14;

	// Field positions
	localparam int OTG_INT_VBUS_BIT = 0;
	localparam int OTG_EXT_VBUS_BIT = 1;
	localparam int OTG_HOST_BIT     = 2;
	localparam int FUNC_SUSPEND_BIT = 0;
	localparam int INTF_SERIAL6_BIT = 0;
	localparam int INTF_SERIAL3_BIT = 1;
	localparam int TX_KIND_LSB      = 8;
	localparam int RX_VALID_BIT     = 8;
	localparam int ST_PEND_BIT      = 8;
	localparam int ST_ABORT_BIT     = 9;
	localparam int ST_DIR_BIT       = 10;

	// Reset values
	localparam logic [2:0] OTG_CONTROL_REGISTER_RST  = 3'h0;
	localparam logic       FUNCTION_CONTROL_REGISTER_RST = 1'b1;
	localparam logic [1:0] INTF_CTRL_RST = 2'h0;

	// Bus maps outside synchronous mode
	localparam logic [7:0] LP_OE_MASK  = 8'hff;
	localparam logic [7:0] SER_OE_MASK = 8'h38;

	typedef enum logic [1:0] {
		KIND_RXCMD = 2'h0,
		KIND_USB   = 2'h1,
		KIND_REGRD = 2'h2
	} send_kind_t;

	typedef enum logic [7:0] {
		ST_BOOT     = 8'h01,
		ST_IDLE     = 8'h02,
		ST_RECV     = 8'h04,
		ST_TURN_OUT = 8'h08,
		ST_SEND     = 8'h10,
		ST_TURN_IN  = 8'h20,
		ST_LOWPWR   = 8'h40,
		ST_SERIAL   = 8'h80
	} phy_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic [7:0] data_o;
		logic [7:0] data_oe;
		logic       dir;
		logic       dir_oe;
		logic       nxt;
		logic       nxt_oe;
	} ulpi_pins_t;

endpackage

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync
	import ulpi_phy_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	// Raw pins and filtered levels
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} sync_t;

	sync_t sync_reg;
	sync_t sync_next;

	// A bit changes only once stages two and three agree; otherwise it holds
	always_comb begin
		sync_next = sync_reg;
		sync_next.s1 = d;
		sync_next.s2 = sync_reg.s1;
		sync_next.s3 = sync_reg.s2;
		sync_next.q = (sync_reg.s2 & sync_reg.s3) | (sync_reg.q & (sync_reg.s2 | sync_reg.s3));
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign q = sync_reg.q;

endmodule

// [dv/ulpi_link_model.sv]
`timescale 1ns/1ps
module ulpi_link_model (
	// Device pins seen by the link
	input  wire logic       ifc_clk,
	input  wire logic       dir,
	input  wire logic       nxt,
	// Link drive
	output logic            stp,
	output logic            drv,
	output logic [7:0]      dout
);
	initial begin
		stp = 1'b0;
		drv = 1'b0;
		dout = 8'h00;
	end

	// Release the bus whenever the device owns it, else contention
	always @(posedge ifc_clk) drv <= ~dir;

	// Command held until throttled, one byte, then a stop with the byte held
	task automatic send(input logic [7:0] cmd, input logic [7:0] val);
		int n;
		@(posedge ifc_clk);
		dout <= cmd;
		n = 0;
		while (nxt !== 1'b1 && n < 40) begin
			@(posedge ifc_clk);
			n++;
		end
		dout <= val;
		repeat (2) @(posedge ifc_clk);
		stp <= 1'b1;
		@(posedge ifc_clk);
		stp <= 1'b0;
		dout <= 8'h00;
	endtask

	// Abort while the device owns the bus, or a wake request when held long
	task automatic hold_stp(input int ticks);
		@(posedge ifc_clk);
		stp <= 1'b1;
		repeat (ticks) @(posedge ifc_clk);
		stp <= 1'b0;
	endtask
endmodule

// [dv/test_ulpi_phy_bus_control.sv]
`timescale 1ns/1ps
module test_ulpi_phy_bus_control;
	import ulpi_phy_pkg::*;
	logic        ref_clk, rstn, cs_n, int_req, stp, drv, ifc_clk;
	logic        sw_o, sw_oe, int_vbus, slverr, dir_q;
	logic [1:0]  ls;
	logic [7:0]  dout, data_w, b;
	logic [31:0] rd, w;
	apb_req_t    req;
	apb_rsp_t    rsp;
	ulpi_pins_t  ulpi;
	time         t;
	int          error_cnt, num_checks;

	// Weak pull-downs win where nobody drives
	assign data_w = (ulpi.data_oe & ulpi.data_o) | (~ulpi.data_oe & {8{drv}} & dout);

	ulpi_phy_ctrl DUT (
		.ref_clk                 (ref_clk),
		.rstn                    (rstn),
		.apb_req                 (req),
		.apb_rsp                 (rsp),
		.ifc_clk                 (ifc_clk),
		.stp                     (stp),
		.chip_select_n           (cs_n),
		.data_i                  (data_w),
		.ulpi                    (ulpi),
		.linestate               (ls),
		.int_req                 (int_req),
		.vbus_switch_enable_n_o  (sw_o),
		.vbus_switch_enable_n_oe (sw_oe),
		.internal_vbus_enable    (int_vbus)
	);

	ulpi_link_model link (
		.ifc_clk (ifc_clk),
		.dir     (ulpi.dir),
		.nxt     (ulpi.nxt),
		.stp     (stp),
		.drv     (drv),
		.dout    (dout)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	// Setup, then access held until pready is seen at an edge
	task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		req <= '{1'b1, 1'b0, we, a, d};
		@(posedge ref_clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		chk(rsp.pready, 1'b1);
		rd = rsp.prdata;
		slverr = rsp.pslverr;
		req <= '0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	function automatic logic pin(input int s);
		return s == 0 ? ulpi.dir : s == 1 ? ulpi.nxt : ulpi.data_oe[3];
	endfunction

	task automatic wt(input int s, input logic v);
		int n;
		n = 0;
		while (pin(s) !== v && n < 300) begin
			@(posedge ref_clk);
			n++;
		end
	endtask

	task automatic wake(input logic [7:0] a, input logic [31:0] e);
		link.hold_stp(4);
		wt(0, 1'b0);
		chk(ulpi.dir, 1'b0);
		repeat (12) @(posedge ref_clk);
		rdc(a, e);
		rdc(STATUS_OFS, 32'h2);
	endtask

	// Bus watch: device quiet while the link owns it, and at every turnaround
	always @(posedge ref_clk) begin
		if (rstn === 1'b1 && ulpi.dir === 1'b0) chk(ulpi.data_oe, 8'h0);
		if (rstn === 1'b1 && ulpi.dir !== dir_q) chk(ulpi.data_oe, 8'h0);
		dir_q <= ulpi.dir;
	end

	initial begin
		#100000;
		error_cnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		stop_test();
	end

	initial begin
		error_cnt = 0;
		num_checks = 0;
		rstn = 1'b0;
		cs_n = 1'b0;
		int_req = 1'b0;
		ls = 2'h0;
		req = '0;
		dir_q = 1'b1;
		void'($urandom(32'he8da9b69));
		repeat (6) @(posedge ref_clk);
		chk(ulpi.dir, 1'b1);
		chk({sw_oe, int_vbus, ulpi.data_oe}, 10'h0);
		rstn <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk(ulpi.dir, 1'b1);
		wt(0, 1'b0);
		repeat (16) @(posedge ref_clk);
		rdc(STATUS_OFS, 32'h2);
		rdc(OTG_CONTROL_REGISTER_OFS, 32'(OTG_CONTROL_REGISTER_RST));
		rdc(FUNCTION_CONTROL_REGISTER_OFS, 32'(FUNCTION_CONTROL_REGISTER_RST));
		rdc(INTF_CTRL_OFS, 32'(INTF_CTRL_RST));
		@(posedge ifc_clk);
		t = $time;
		@(posedge ifc_clk);
		chk(32'($time - t), 32'(CLK_DIV * 4));
		@(posedge ref_clk);
		done("boot");

		for (int i = 0; i < 8; i++) begin
			w = $urandom();
			w[2:0] = 3'(i);
			wr(OTG_CONTROL_REGISTER_OFS, w);
			repeat (2) @(posedge ref_clk);
			chk({sw_o, sw_oe}, {1'b0, w[2] & w[1]});
			chk(int_vbus, w[0]);
			rdc(OTG_CONTROL_REGISTER_OFS, {29'h0, w[2:0]});
		end
		apb(1'b1, 8'h40, $urandom());
		chk(slverr, 1'b1);
		wr(OTG_CONTROL_REGISTER_OFS, 32'h0);
		done("vbus");

		for (int k = 0; k < 3; k++) begin
			b = 8'($urandom());
			wr(TX_REQ_OFS, {22'h0, 2'(k), b});
			wt(2, 1'b1);
			chk({ulpi.dir, ulpi.data_o}, {1'b1, b});
			chk(ulpi.nxt, k == 1);
			wt(0, 1'b0);
			chk(ulpi.nxt, 1'b0);
			repeat (8) @(posedge ref_clk);
			rdc(STATUS_OFS, 32'h2);
		end
		done("send");

		repeat (3) begin
			b = 8'($urandom());
			fork
				link.send(8'h40 | 8'($urandom_range(1, 63)), b);
				begin
					wt(1, 1'b1);
					chk(ulpi.dir, 1'b0);
				end
			join
			repeat (12) @(posedge ref_clk);
			chk(ulpi.nxt, 1'b0);
			rdc(RX_DATA_OFS, {23'h0, 1'b1, b});
		end
		done("receive");

		wr(TX_REQ_OFS, {22'h0, 2'(KIND_USB), 8'h5a});
		wt(0, 1'b1);
		link.hold_stp(1);
		repeat (4) @(posedge ref_clk);
		chk(ulpi.dir, 1'b0);
		repeat (8) @(posedge ref_clk);
		rdc(STATUS_OFS, 32'h202);
		wr(STATUS_OFS, 32'h0);
		repeat (8) @(posedge ref_clk);
		rdc(STATUS_OFS, 32'h2);
		done("abort");

		ls <= 2'($urandom());
		int_req <= 1'($urandom());
		wr(FUNCTION_CONTROL_REGISTER_OFS, 32'h0);
		wt(2, 1'b1);
		chk(ulpi.data_oe, LP_OE_MASK);
		chk({ulpi.dir, ulpi.data_o}, {1'b1, 4'h0, int_req, 1'b0, ls});
		cs_n <= 1'b1;
		// Synchroniser plus up to one interface tick before the pins float
		repeat (12) @(posedge ref_clk);
		chk({ulpi.data_oe, ulpi.dir_oe, ulpi.nxt_oe}, 10'h0);
		link.hold_stp(3);
		repeat (4) @(posedge ref_clk);
		cs_n <= 1'b0;
		repeat (12) @(posedge ref_clk);
		chk({ulpi.dir_oe, ulpi.nxt_oe, ulpi.dir, ulpi.data_oe}, {3'h7, LP_OE_MASK});
		wake(FUNCTION_CONTROL_REGISTER_OFS, 32'h1);
		done("low power");

		for (int m = 1; m < 3; m++) begin
			ls <= 2'($urandom());
			wr(INTF_CTRL_OFS, 32'(m));
			wt(2, 1'b1);
			chk({ulpi.dir, ulpi.data_oe}, {1'b1, SER_OE_MASK});
			chk(ulpi.data_o[5:3], {ls, int_req});
			wake(INTF_CTRL_OFS, 32'h0);
		end
		done("serial");
		stop_test();
	end
endmodule
